// ==== rtl/seg_pkg.sv ====
package seg_pkg;
   // Sizes of the event bank and of the routing network
   localparam int unsigned NUM_EVENTS = 16;
   localparam int unsigned NUM_CHANNELS = 16;
   localparam int unsigned CHAN_IDX_W = 4;
   localparam int unsigned IDX_W = 4;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // Register byte offsets
   localparam logic [11:0] TASK_BASE = 12'h000;
   localparam logic [11:0] SUB_BASE = 12'h080;
   localparam logic [11:0] EVT_BASE = 12'h100;
   localparam logic [11:0] PUB_BASE = 12'h180;
   localparam logic [11:0] MASK_OFS = 12'h300;
   localparam logic [11:0] MASK_SET_OFS = 12'h304;
   localparam logic [11:0] MASK_CLR_OFS = 12'h308;
   localparam logic [11:0] PEND_OFS = 12'h310;

   // Bank decode: a bank of sixteen words spans address bits 5..2
   localparam int unsigned BANK_LSB = 6;
   localparam int unsigned WORD_LSB = 2;

   // Field positions
   localparam int unsigned TRIG_BIT = 0;
   localparam int unsigned FLAG_BIT = 0;
   localparam int unsigned CFG_EN_BIT = 31;
   localparam int unsigned CHAN_IDX_LSB = 0;

   // Reset values
   localparam logic [31:0] CFG_RESET = 32'h00000000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] CHAN_RESET = 16'h0000;
   localparam logic [31:0] RDATA_RESET = 32'h00000000;

   // Flag to interrupt latency in mclk cycles
   localparam int unsigned IRQ_LATENCY_CYC = 1;

   // Register regions seen by the decoder
   typedef enum logic [2:0] {
      REG_NONE = 3'b000,
      REG_TASK = 3'b001,
      REG_SUB = 3'b010,
      REG_EVT = 3'b011,
      REG_PUB = 3'b100,
      REG_MASK = 3'b101,
      REG_SET = 3'b110,
      REG_CLR = 3'b111
   } region_t;
endpackage : seg_pkg

// ==== rtl/event_lane.sv ====
`timescale 1ns/100ps
module event_lane #(
   parameter int unsigned CHAN_W = seg_pkg::CHAN_IDX_W
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic trig_wr,
   input wire logic flag_wr,
   input wire logic pend_clr,
   input wire logic sub_wr,
   input wire logic pub_wr,
   input wire logic [seg_pkg::DATA_W-1:0] wdata,
   input wire logic [(1<<CHAN_W)-1:0] chan_activity,
   output logic flag_q,
   output logic [seg_pkg::DATA_W-1:0] sub_cfg,
   output logic [seg_pkg::DATA_W-1:0] pub_cfg,
   output logic [(1<<CHAN_W)-1:0] pub_vec
);
   import seg_pkg::*;

   logic sub_en_q;
   logic [CHAN_W-1:0] sub_idx_q;
   logic pub_en_q;
   logic [CHAN_W-1:0] pub_idx_q;
   logic fire;

   // Subscribe configuration, cleared at reset
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sub_en_q <= 1'b0;
         sub_idx_q <= '0;
      end else if (sub_wr) begin
         sub_en_q <= wdata[CFG_EN_BIT];
         sub_idx_q <= wdata[CHAN_IDX_LSB +: CHAN_W];
      end
   end

   // Publish configuration, cleared at reset
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pub_en_q <= 1'b0;
         pub_idx_q <= '0;
      end else if (pub_wr) begin
         pub_en_q <= wdata[CFG_EN_BIT];
         pub_idx_q <= wdata[CHAN_IDX_LSB +: CHAN_W];
      end
   end

   // Task fires from software or from the subscribed channel
   assign fire = (trig_wr & wdata[TRIG_BIT])
      | (sub_en_q & chan_activity[sub_idx_q]);

   // Event flag; a firing task beats a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         flag_q <= 1'b0;
      end else if (fire) begin
         flag_q <= 1'b1;
      end else if (flag_wr) begin
         flag_q <= wdata[FLAG_BIT];
      end else if (pend_clr) begin
         flag_q <= 1'b0;
      end
   end

   // Readback of both configurations
   always_comb begin
      sub_cfg = CFG_RESET;
      sub_cfg[CFG_EN_BIT] = sub_en_q;
      sub_cfg[CHAN_IDX_LSB +: CHAN_W] = sub_idx_q;
      pub_cfg = CFG_RESET;
      pub_cfg[CFG_EN_BIT] = pub_en_q;
      pub_cfg[CHAN_IDX_LSB +: CHAN_W] = pub_idx_q;
   end

   // One-hot request on the chosen channel while the event fires
   always_comb begin
      pub_vec = '0;
      if (fire && pub_en_q) begin
         pub_vec[pub_idx_q] = 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_sub_fires_flag: assert property (
      (sub_en_q && chan_activity[sub_idx_q]) |=> flag_q)
      else $error("subscribed channel did not set the flag");

   a_pub_one_hot: assert property (
      (fire && pub_en_q) |-> (pub_vec == (1 << pub_idx_q)))
      else $error("publish request on wrong channel");
endmodule : event_lane

// ==== rtl/software_event_generator.sv ====
// Summary of operation
// - Writing one to task word n sets event flag n.
// - An enabled subscription fires task n when its channel is active.
// - Event flag word n reads one once generated, zero otherwise.
// - An enabled publication signals event n on its chosen channel.
// - Mask register holds one interrupt enable bit per event flag.
// - Writing one to a mask-set bit sets that enable bit.
// - Writing one to a mask-clear bit clears that enable bit.
// - Interrupt rises one cycle after an enabled flag becomes set.
`timescale 1ns/100ps
module software_event_generator (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [seg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [seg_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [seg_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [seg_pkg::NUM_CHANNELS-1:0] chan_activity,
   output logic [seg_pkg::NUM_CHANNELS-1:0] chan_publish,
   output logic irq
);
   import seg_pkg::*;

   // Decode an address into its register region
   function automatic region_t addr_region(
      input logic [ADDR_W-1:0] a
   );
      region_t r;
      r = REG_NONE;
      if (a[WORD_LSB-1:0] == 2'b00) begin
         if (a[ADDR_W-1:BANK_LSB] == TASK_BASE[ADDR_W-1:BANK_LSB]) begin
            r = REG_TASK;
         end else if (a[ADDR_W-1:BANK_LSB]
                      == SUB_BASE[ADDR_W-1:BANK_LSB]) begin
            r = REG_SUB;
         end else if (a[ADDR_W-1:BANK_LSB]
                      == EVT_BASE[ADDR_W-1:BANK_LSB]) begin
            r = REG_EVT;
         end else if (a[ADDR_W-1:BANK_LSB]
                      == PUB_BASE[ADDR_W-1:BANK_LSB]) begin
            r = REG_PUB;
         end else if (a == MASK_OFS) begin
            r = REG_MASK;
         end else if (a == MASK_SET_OFS) begin
            r = REG_SET;
         end else if (a == MASK_CLR_OFS) begin
            r = REG_CLR;
         end
      end
      return r;
   endfunction : addr_region

   // Word index inside a sixteen-word bank
   function automatic logic [IDX_W-1:0] addr_index(
      input logic [ADDR_W-1:0] a
   );
      return a[WORD_LSB +: IDX_W];
   endfunction : addr_index

   region_t wr_region;
   region_t rd_region;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] rd_idx;
   logic [NUM_EVENTS-1:0] wr_sel;
   logic wr_task;
   logic wr_sub;
   logic wr_evt;
   logic wr_pub;
   logic wr_pend;
   logic [NUM_EVENTS-1:0] flags;
   logic [NUM_EVENTS-1:0] mask_q;
   logic [NUM_EVENTS-1:0] mask_d;
   logic [DATA_W-1:0] sub_cfg [NUM_EVENTS];
   logic [DATA_W-1:0] pub_cfg [NUM_EVENTS];
   logic [NUM_CHANNELS-1:0] pub_vec [NUM_EVENTS];
   logic [NUM_CHANNELS-1:0] pub_or;
   logic [DATA_W-1:0] rd_d;
   logic irq_q;
   logic [NUM_CHANNELS-1:0] chan_publish_q;
   logic [DATA_W-1:0] reg_rdata_q;
   logic pend_hit;

   // Write and read decode share the same address bus
   assign wr_region = addr_region(reg_addr);
   assign rd_region = addr_region(reg_addr);
   assign wr_idx = addr_index(reg_addr);
   assign rd_idx = addr_index(reg_addr);
   assign wr_sel = NUM_EVENTS'(1) << wr_idx;

   // The pending word sits outside the bank regions
   assign pend_hit = (reg_addr == PEND_OFS);

   // Write strobes per region
   assign wr_task = reg_wr && (wr_region == REG_TASK);
   assign wr_sub = reg_wr && (wr_region == REG_SUB);
   assign wr_evt = reg_wr && (wr_region == REG_EVT);
   assign wr_pub = reg_wr && (wr_region == REG_PUB);
   assign wr_pend = reg_wr && pend_hit;

   // One lane per event: flag, subscription and publication
   for (genvar n = 0; n < NUM_EVENTS; n++) begin : g_lane
      event_lane #(
         .CHAN_W(CHAN_IDX_W)
      ) event_lane_inst (
         .mclk(mclk),
         .reset_n(reset_n),
         .trig_wr(wr_task && wr_sel[n]),
         .flag_wr(wr_evt && wr_sel[n]),
         .pend_clr(wr_pend && reg_wdata[n]),
         .sub_wr(wr_sub && wr_sel[n]),
         .pub_wr(wr_pub && wr_sel[n]),
         .wdata(reg_wdata),
         .chan_activity(chan_activity),
         .flag_q(flags[n]),
         .sub_cfg(sub_cfg[n]),
         .pub_cfg(pub_cfg[n]),
         .pub_vec(pub_vec[n])
      );
   end

   // Next interrupt mask: plain write, set-only and clear-only views
   always_comb begin
      mask_d = mask_q;
      if (reg_wr) begin
         unique case (wr_region)
            REG_MASK: mask_d = reg_wdata[NUM_EVENTS-1:0];
            REG_SET: mask_d = mask_q | reg_wdata[NUM_EVENTS-1:0];
            REG_CLR: mask_d = mask_q & ~reg_wdata[NUM_EVENTS-1:0];
            default: mask_d = mask_q;
         endcase
      end
   end

   // Interrupt mask register
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         mask_q <= MASK_RESET;
      end else begin
         mask_q <= mask_d;
      end
   end

   // Registered interrupt; a flop keeps the line glitch free
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags & mask_q);
      end
   end

   assign irq = irq_q;

   // Merge every lane's publication onto the channel network
   always_comb begin
      pub_or = '0;
      for (int unsigned n = 0; n < NUM_EVENTS; n++) begin
         pub_or = pub_or | pub_vec[n];
      end
   end

   // Publish pulses are registered so the network sees clean strobes
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         chan_publish_q <= CHAN_RESET;
      end else begin
         chan_publish_q <= pub_or;
      end
   end

   assign chan_publish = chan_publish_q;

   // Read mux; task words are write-only and read as zero
   always_comb begin
      rd_d = RDATA_RESET;
      if (pend_hit) begin
         rd_d[NUM_EVENTS-1:0] = flags;
      end else begin
         unique case (rd_region)
            REG_SUB: rd_d = sub_cfg[rd_idx];
            REG_EVT: rd_d[FLAG_BIT] = flags[rd_idx];
            REG_PUB: rd_d = pub_cfg[rd_idx];
            REG_MASK, REG_SET, REG_CLR: begin
               rd_d[NUM_EVENTS-1:0] = mask_q;
            end
            default: rd_d = RDATA_RESET;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         reg_rdata_q <= RDATA_RESET;
      end else if (reg_rd) begin
         reg_rdata_q <= rd_d;
      end else begin
         reg_rdata_q <= RDATA_RESET;
      end
   end

   assign reg_rdata = reg_rdata_q;

   // Helper state that only the checks below read
   logic [IDX_W-1:0] chk_idx_q;
   logic [NUM_EVENTS-1:0] chk_flags_q;
   logic [NUM_EVENTS-1:0] chk_sel_q;
   logic [CHAN_IDX_W-1:0] chk_chan_q;
   logic cfg_en_any;

   // Remember the index and flags seen at the previous edge
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         chk_idx_q <= '0;
         chk_flags_q <= '0;
         chk_sel_q <= '0;
         chk_chan_q <= '0;
      end else begin
         chk_idx_q <= rd_idx;
         chk_flags_q <= flags;
         chk_sel_q <= wr_sel;
         chk_chan_q <= pub_cfg[wr_idx][CHAN_IDX_LSB +: CHAN_IDX_W];
      end
   end

   // Any enabled subscription or publication, for the reset check
   always_comb begin
      cfg_en_any = 1'b0;
      for (int unsigned n = 0; n < NUM_EVENTS; n++) begin
         cfg_en_any = cfg_en_any | sub_cfg[n][CFG_EN_BIT]
            | pub_cfg[n][CFG_EN_BIT];
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // Software trigger write with the task bit high
   sequence trig_write_s;
      wr_task && reg_wdata[TRIG_BIT];
   endsequence

   // An enabled flag appears where none was before
   sequence flag_rise_s;
      !(|(flags & mask_q)) ##1 (|(flags & mask_q));
   endsequence

   // Read of an event flag word
   sequence evt_read_s;
      reg_rd && (rd_region == REG_EVT) && !pend_hit;
   endsequence

   // Pending clear with no channel able to refire a lane
   sequence pend_clear_s;
      wr_pend && (chan_activity == '0);
   endsequence

   // Write of a subscription word
   sequence sub_write_s;
      reg_wr && (wr_region == REG_SUB);
   endsequence

   a_task_sets_flag: assert property (
      trig_write_s |=> ((flags & chk_sel_q) == chk_sel_q))
      else $error("task write did not set its event flag");

   a_task_reads_zero: assert property (
      (reg_rd && rd_region == REG_TASK) |=> (reg_rdata == RDATA_RESET))
      else $error("write-only task word returned data");

   a_flag_readback: assert property (
      evt_read_s |=> (reg_rdata[FLAG_BIT] == chk_flags_q[chk_idx_q]
                      && reg_rdata[DATA_W-1:1] == '0))
      else $error("event flag read back wrong");

   a_publish_path: assert property (
      (|pub_or) |=> (chan_publish == $past(pub_or)))
      else $error("publish pulse lost on the way out");

   a_mask_write: assert property (
      (reg_wr && wr_region == REG_MASK)
      |=> (mask_q == $past(reg_wdata[NUM_EVENTS-1:0])))
      else $error("mask write not stored");

   a_mask_set: assert property (
      (reg_wr && wr_region == REG_SET)
      |=> (mask_q == ($past(mask_q) | $past(reg_wdata[NUM_EVENTS-1:0]))))
      else $error("mask set did not merge");

   a_mask_clear: assert property (
      (reg_wr && wr_region == REG_CLR)
      |=> (mask_q == ($past(mask_q) & ~$past(reg_wdata[NUM_EVENTS-1:0]))))
      else $error("mask clear did not remove bits");

   a_irq_latency: assert property (
      flag_rise_s |=> irq)
      else $error("interrupt late after enabled flag");

   a_irq_hold: assert property (
      (|(flags & mask_q)) [*2] |-> irq)
      else $error("interrupt dropped while flag enabled");

   a_irq_quiet: assert property (
      (!(|(flags & mask_q))) [*2] |-> !irq)
      else $error("interrupt high with no enabled flag");

   a_reset_state: assert property (
      $rose(reset_n) |-> (flags == '0 && mask_q == MASK_RESET
                          && !irq && chan_publish == CHAN_RESET))
      else $error("state not zero after reset");

   a_rdata_window: assert property (
      !reg_rd |=> (reg_rdata == RDATA_RESET))
      else $error("read data outside its cycle");

   a_pend_clear: assert property (
      pend_clear_s
      |=> ((flags & $past(reg_wdata[NUM_EVENTS-1:0])) == '0))
      else $error("pending clear left a flag set");

   a_pend_readback: assert property (
      (reg_rd && pend_hit)
      |=> (reg_rdata[NUM_EVENTS-1:0] == chk_flags_q
           && reg_rdata[DATA_W-1:NUM_EVENTS] == '0))
      else $error("pending word read back wrong");

   a_task_publish: assert property (
      (trig_write_s && pub_cfg[wr_idx][CFG_EN_BIT])
      |=> chan_publish[chk_chan_q])
      else $error("task write not published on its channel");

   a_unmapped_write: assert property (
      (reg_wr && wr_region == REG_NONE) |=> $stable(mask_q))
      else $error("unmapped write changed the mask");

   a_sub_write: assert property (
      sub_write_s
      |=> (sub_cfg[chk_idx_q][CFG_EN_BIT] == $past(reg_wdata[CFG_EN_BIT])
           && sub_cfg[chk_idx_q][CHAN_IDX_LSB +: CHAN_IDX_W]
              == $past(reg_wdata[CHAN_IDX_LSB +: CHAN_IDX_W])))
      else $error("subscription write not stored");

   a_pub_write: assert property (
      (reg_wr && wr_region == REG_PUB)
      |=> (pub_cfg[chk_idx_q][CFG_EN_BIT] == $past(reg_wdata[CFG_EN_BIT])
           && pub_cfg[chk_idx_q][CHAN_IDX_LSB +: CHAN_IDX_W]
              == $past(reg_wdata[CHAN_IDX_LSB +: CHAN_IDX_W])))
      else $error("publication write not stored");

   a_reset_config: assert property (
      $rose(reset_n) |-> !cfg_en_any)
      else $error("configuration enabled after reset");
endmodule : software_event_generator

// ==== testbench/chan_net_model.sv ====
`timescale 1ns/100ps
module chan_net_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [15:0] fire,
   input wire logic [15:0] chan_publish,
   output logic [15:0] chan_activity,
   output logic [15:0] pub_seen
);
   // Channel network: drives activity one cycle after a bench request
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         chan_activity <= 16'h0000;
      end else begin
         chan_activity <= fire;
      end
   end

   // Publish pulses last one cycle, so they are gathered into a sticky log
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pub_seen <= 16'h0000;
      end else begin
         pub_seen <= pub_seen | chan_publish;
      end
   end
endmodule : chan_net_model

// ==== testbench/software_event_generator_tb.sv ====
`timescale 1ns/100ps
module software_event_generator_tb;
   import seg_pkg::*;
   logic mclk, reset_n, reg_wr, reg_rd, irq;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [15:0] chan_activity, chan_publish, fire, pub_seen;
   int fails, checks;

   software_event_generator software_event_generator_inst (
      .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .chan_activity(chan_activity),
      .chan_publish(chan_publish), .irq(irq));

   chan_net_model chan_net_model_inst (
      .mclk(mclk), .reset_n(reset_n), .fire(fire),
      .chan_publish(chan_publish), .chan_activity(chan_activity),
      .pub_seen(pub_seen));

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   task automatic chk32(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk32

   task automatic chk1(input string nm, input logic e, g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1

   // One-cycle write strobe; the write lands at the edge that ends it
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   task automatic rdchk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
      rd(a, d);
      chk32(nm, e, d);
   endtask : rdchk

   // Watchdog cuts a hang short
   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      final_report();
   end

   initial begin
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 32'h00000000;
      fire = 16'h0000;
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      // Reset values of every register kind except the pending word
      rdchk("sub0", SUB_BASE, 32'h00000000);
      rdchk("pub0", PUB_BASE, 32'h00000000);
      rdchk("flag15", EVT_BASE + 12'h03C, 32'h00000000);
      rdchk("mask", MASK_OFS, 32'h00000000);
      rdchk("task0", TASK_BASE, 32'h00000000);
      chk1("irq", 1'b0, irq);
      $display("test reset done");
      // Mask write, set, clear and an unmapped access
      wr(MASK_OFS, 32'hFFFF0005);
      rdchk("mask", MASK_OFS, 32'h00000005);
      wr(MASK_SET_OFS, 32'h00000002);
      rdchk("mask_set", MASK_SET_OFS, 32'h00000007);
      wr(MASK_CLR_OFS, 32'h00000001);
      rdchk("mask_clr", MASK_CLR_OFS, 32'h00000006);
      wr(12'h200, 32'hFFFFFFFF);
      rdchk("unmapped", 12'h200, 32'h00000000);
      rdchk("mask", MASK_OFS, 32'h00000006);
      $display("test mask done");
      // Interrupt latency: flag in the next cycle, irq one cycle after
      wr(TASK_BASE + 12'h004, 32'h00000001);
      #1 chk1("irq_c1", 1'b0, irq);
      @(posedge mclk);
      #1 chk1("irq_c2", 1'b1, irq);
      wr(EVT_BASE + 12'h004, 32'h00000000);
      @(posedge mclk);
      #1 chk1("irq_drop", 1'b0, irq);
      // A masked flag stays quiet but still reads as generated
      wr(TASK_BASE, 32'h00000001);
      repeat (2) @(posedge mclk);
      #1 chk1("irq_masked", 1'b0, irq);
      rdchk("flag0", EVT_BASE, 32'h00000001);
      wr(EVT_BASE, 32'h00000000);
      $display("test latency done");
      // Every task sets only its own flag; irq holds until all are clear
      wr(MASK_OFS, 32'h0000FFFF);
      for (int n = 0; n < 16; n++) begin
         rdchk("flag_pre", EVT_BASE + 12'(4 * n), 32'h00000000);
         wr(TASK_BASE + 12'(4 * n), 32'h00000001);
         rdchk("flag_set", EVT_BASE + 12'(4 * n), 32'h00000001);
      end
      // Look after the edge settles, never in the edge's own time step
      for (int n = 0; n < 16; n++) begin
         #1 chk1("irq_hold", 1'b1, irq);
         wr(EVT_BASE + 12'(4 * n), 32'h00000000);
      end
      @(posedge mclk);
      #1 chk1("irq_all_clear", 1'b0, irq);
      $display("test lanes done");
      // Subscribe on channel 3, publish on 5; a disabled lane on 7
      wr(SUB_BASE + 12'h008, 32'h80000003);
      wr(PUB_BASE + 12'h008, 32'h80000005);
      wr(SUB_BASE + 12'h00C, 32'h00000007);
      rdchk("sub2", SUB_BASE + 12'h008, 32'h80000003);
      rdchk("pub2", PUB_BASE + 12'h008, 32'h80000005);
      chk32("pub_idle", 32'h00000000, {16'h0000, pub_seen});
      @(posedge mclk);
      fire <= 16'h0088;
      @(posedge mclk);
      fire <= 16'h0000;
      repeat (4) @(posedge mclk);
      rdchk("flag2", EVT_BASE + 12'h008, 32'h00000001);
      rdchk("flag3", EVT_BASE + 12'h00C, 32'h00000000);
      chk32("pub_seen", 32'h00000020, {16'h0000, pub_seen});
      chk1("irq_chan", 1'b1, irq);
      $display("test channels done");
      // Software trigger publishes one single-cycle pulse
      wr(TASK_BASE + 12'h008, 32'h00000001);
      #1 d = {16'h0000, chan_publish};
      chk32("pub_pulse", 32'h00000020, d);
      @(posedge mclk);
      #1 d = {16'h0000, chan_publish};
      chk32("pub_end", 32'h00000000, d);
      // Pending word shows every flag; writing one clears it
      rdchk("pend", PEND_OFS, 32'h00000004);
      wr(PEND_OFS, 32'h00000004);
      rdchk("pend_clr", PEND_OFS, 32'h00000000);
      chk1("irq_pend", 1'b0, irq);
      $display("test pending done");
      // Reset in mid-run drops configurations and enables again
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rdchk("sub2_rst", SUB_BASE + 12'h008, 32'h00000000);
      rdchk("pub2_rst", PUB_BASE + 12'h008, 32'h00000000);
      rdchk("mask_rst", MASK_OFS, 32'h00000000);
      chk1("irq_rst", 1'b0, irq);
      $display("test reset again done");
      final_report();
   end
endmodule : software_event_generator_tb
